// ---- shared/vlfrx_pkg.sv ----
// constants, carriers and register map of the variable-length field receiver
package vlfrx_pkg;
   // register address width, fifo depth, byte width and field count
   localparam int unsigned REG_AW = 6;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned NUM_FIELDS = 5;
   // byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_FLEN_BASE = 6'h04;
   localparam logic [5:0] OFS_FLEN_STEP = 6'h04;
   localparam logic [5:0] OFS_STAT = 6'h18;
   localparam logic [5:0] OFS_DATA = 6'h1c;
   // decoded register slots
   localparam logic [2:0] SLOT_CTRL = 3'h0;
   localparam logic [2:0] SLOT_FLEN1 = 3'h1;
   localparam logic [2:0] SLOT_STAT = 3'h6;
   localparam logic [2:0] SLOT_DATA = 3'h7;
   // control word fields
   localparam int unsigned CTRL_LFLD_LSB = 0;
   localparam int unsigned CTRL_VFLD_LSB = 4;
   localparam int unsigned CTRL_TWO_BIT = 8;
   localparam int unsigned CTRL_MSBF_BIT = 9;
   localparam int unsigned CTRL_STRIP_BIT = 10;
   localparam int unsigned CTRL_LOFF_LSB = 16;
   // status word fields
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_CERR_BIT = 1;
   localparam int unsigned STAT_CFGOK_BIT = 2;
   localparam int unsigned STAT_PKTS_LSB = 8;
   localparam int unsigned STAT_LVL_LSB = 16;
   // data word fields
   localparam int unsigned DATA_VALID_BIT = 8;
   // reset values
   localparam logic [2:0] RST_LEN_FLD = 3'h1;
   localparam logic [2:0] RST_VAR_FLD = 3'h2;
   localparam logic [15:0] RST_FLEN = 16'h0001;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {ST_IDLE, ST_RUN} vlfrx_state_e;

   typedef struct packed {
      logic [2:0] len_fld;
      logic [2:0] var_fld;
      logic two;
      logic msbf;
      logic strip;
      logic [7:0] len_off;
   } vlfrx_cfg_s;

   typedef struct packed {
      logic first;
      logic [7:0] data;
   } vlfrx_rxb_s;

   typedef struct packed {
      vlfrx_cfg_s cfg;
      logic [NUM_FIELDS-1:0][15:0] flen;
      vlfrx_state_e st;
      logic [2:0] fld;
      logic [15:0] cnt;
      logic [15:0] vlen;
      logic [7:0] lenlo;
      logic len_seen;
      logic [7:0] pkts;
      logic cfg_err;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } vlfrx_top_s;
endpackage

// ---- verilog/vlfrx_top.sv ----
// variable-length field packet receiver with byte fifo and axi4-lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps

// byte fifo, flip-flop storage, power-of-two depth
module vlfrx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } vlfrx_fifo_s;

   vlfrx_fifo_s s_ff;
   vlfrx_fifo_s nxt_s;
   logic wr;
   logic rd;

   // depth must be a power of two so the pointers wrap by themselves
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
   end

   // flags straight from the count
   assign in_ready = (s_ff.cnt != CW'(DEPTH));
   assign out_valid = (s_ff.cnt != '0);
   assign out_data = s_ff.mem[s_ff.rp];
   assign level = s_ff.cnt;

   // next state
   always_comb begin
      nxt_s = s_ff;
      wr = in_valid && in_ready;
      rd = out_valid && out_ready;
      if (wr) begin
         nxt_s.mem[s_ff.wp] = in_data;
         nxt_s.wp = s_ff.wp + PW'(1);
      end
      if (rd) begin
         nxt_s.rp = s_ff.rp + PW'(1);
      end
      if (wr && !rd) begin
         nxt_s.cnt = s_ff.cnt + CW'(1);
      end else if (rd && !wr) begin
         nxt_s.cnt = s_ff.cnt - CW'(1);
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule

// Function
// - length field must precede the variable field in the packet.
// - length value is taken only from a configured field one to four.
// - variable field may only be field two, three, four or five.
// - the length-carrying field has a fixed configured size.
// - fixed fields may sit between the length field and variable field.
// - length value is one or two bytes wide by configuration.
// - two-byte length assembled least or most significant byte first.
// - length bytes either stored in the receive queue or stripped.
// - position of the length bytes is configured, never discovered.
// - otherwise reception runs field by field as configured fixed fields.
module vlfrx_top #(
   parameter int unsigned DEPTH = vlfrx_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [vlfrx_pkg::REG_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [vlfrx_pkg::REG_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // received byte stream after sync word
   input wire logic rx_valid,
   input wire vlfrx_pkg::vlfrx_rxb_s rx_byte,
   output logic rx_ready
);
   import vlfrx_pkg::*;

   localparam int unsigned LW = $clog2(DEPTH+1);

   if (DEPTH < 2 || LW > 16) begin : g_bad_depth
      $error("fifo depth out of range for the status word");
   end

   vlfrx_top_s s_ff;
   vlfrx_top_s nxt_s;
   logic [15:0] cur_len;
   logic [15:0] off16;
   logic is_len;
   logic keep;
   logic fdone;
   logic take;
   logic push;
   logic pop;
   logic good;
   logic wr_go;
   logic rd_go;
   logic [3:0] wdec;
   logic [3:0] rdec;
   logic f_in_ready;
   logic [7:0] f_data;
   logic f_valid;
   logic [LW-1:0] f_level;
   logic [31:0] fl_merge;

   // byte lanes merged under the write strobes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   // address to {hit, slot}
   function automatic logic [3:0] reg_dec(input logic [REG_AW-1:0] a);
      logic [REG_AW-1:0] w;
      w = {a[REG_AW-1:2], 2'b00};
      reg_dec = 4'h0;
      if (w == OFS_CTRL) begin
         reg_dec = {1'b1, SLOT_CTRL};
      end
      for (int i = 0; i < NUM_FIELDS; i++) begin
         if (w == OFS_FLEN_BASE + 6'(i) * OFS_FLEN_STEP) begin
            reg_dec = {1'b1, SLOT_FLEN1 + 3'(i)};
         end
      end
      if (w == OFS_STAT) begin
         reg_dec = {1'b1, SLOT_STAT};
      end
      if (w == OFS_DATA) begin
         reg_dec = {1'b1, SLOT_DATA};
      end
   endfunction

   // control word packing
   function automatic logic [31:0] ctrl_word(input vlfrx_cfg_s c);
      ctrl_word = 32'h0000_0000;
      ctrl_word[CTRL_LFLD_LSB +: 3] = c.len_fld;
      ctrl_word[CTRL_VFLD_LSB +: 3] = c.var_fld;
      ctrl_word[CTRL_TWO_BIT] = c.two;
      ctrl_word[CTRL_MSBF_BIT] = c.msbf;
      ctrl_word[CTRL_STRIP_BIT] = c.strip;
      ctrl_word[CTRL_LOFF_LSB +: 8] = c.len_off;
   endfunction

   function automatic vlfrx_cfg_s ctrl_cfg(input logic [31:0] w);
      ctrl_cfg.len_fld = w[CTRL_LFLD_LSB +: 3];
      ctrl_cfg.var_fld = w[CTRL_VFLD_LSB +: 3];
      ctrl_cfg.two = w[CTRL_TWO_BIT];
      ctrl_cfg.msbf = w[CTRL_MSBF_BIT];
      ctrl_cfg.strip = w[CTRL_STRIP_BIT];
      ctrl_cfg.len_off = w[CTRL_LOFF_LSB +: 8];
   endfunction

   // layout check: length field 1..4, variable 2..5 and later, bytes fit
   function automatic logic cfg_ok(input vlfrx_cfg_s c, input logic [4:0][15:0] fl);
      logic [15:0] need;
      need = {8'h00, c.len_off} + (c.two ? 16'h0002 : 16'h0001);
      cfg_ok = (c.len_fld >= 3'h1) && (c.len_fld <= 3'h4) &&
               (c.var_fld >= 3'h2) && (c.var_fld <= 3'h5) &&
               (c.var_fld > c.len_fld) &&
               (fl[c.len_fld - 3'h1] >= need);
   endfunction

   // size of a field: configured, or the decoded length for the variable one
   function automatic logic [15:0] fld_len(input logic [2:0] f, input vlfrx_cfg_s c,
                                           input logic [4:0][15:0] fl, input logic [15:0] v);
      if (f == c.var_fld) begin
         fld_len = v;
      end else if (f >= 3'h1 && f <= 3'h5) begin
         fld_len = fl[f - 3'h1];
      end else begin
         fld_len = 16'h0000;
      end
   endfunction

   // queue between parser and the data register
   vlfrx_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data(rx_byte.data),
      .in_valid(push),
      .in_ready(f_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(pop),
      .level(f_level)
   );

   // bus handshakes, one write and one read in flight
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_ff.bvalid;
   assign rd_go = s_axi_arvalid && !s_ff.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !s_ff.rvalid;
   assign s_axi_bvalid = s_ff.bvalid;
   assign s_axi_bresp = s_ff.bresp;
   assign s_axi_rvalid = s_ff.rvalid;
   assign s_axi_rdata = s_ff.rdata;
   assign s_axi_rresp = s_ff.rresp;
   assign wdec = reg_dec(s_axi_awaddr);
   assign rdec = reg_dec(s_axi_araddr);
   assign pop = rd_go && (rdec == {1'b1, SLOT_DATA}) && f_valid;

   // parser decode of the current byte
   assign good = cfg_ok(s_ff.cfg, s_ff.flen);
   assign off16 = {8'h00, s_ff.cfg.len_off};
   assign cur_len = fld_len(s_ff.fld, s_ff.cfg, s_ff.flen, s_ff.vlen);
   assign is_len = (s_ff.st == ST_RUN) && (s_ff.fld == s_ff.cfg.len_fld) &&
                   ((s_ff.cnt == off16) || (s_ff.cfg.two && s_ff.cnt == off16 + 16'h0001));
   assign keep = !(s_ff.cfg.strip && is_len);
   assign fdone = (s_ff.st == ST_RUN) && (s_ff.cnt >= cur_len);

   // next state: bus first so hardware flag sets win over clears
   always_comb begin
      nxt_s = s_ff;
      rx_ready = 1'b0;
      take = 1'b0;
      push = 1'b0;
      fl_merge = 32'h0000_0000;
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (wr_go) begin
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = wdec[3] ? RESP_OKAY : RESP_SLVERR;
         if (wdec == {1'b1, SLOT_CTRL}) begin
            nxt_s.cfg = ctrl_cfg(merge(ctrl_word(s_ff.cfg), s_axi_wdata, s_axi_wstrb));
         end else if (wdec[3] && wdec[2:0] >= SLOT_FLEN1 && wdec[2:0] < SLOT_STAT) begin
            fl_merge = merge({16'h0000, s_ff.flen[wdec[2:0] - SLOT_FLEN1]}, s_axi_wdata,
                             s_axi_wstrb);
            nxt_s.flen[wdec[2:0] - SLOT_FLEN1] = fl_merge[15:0]; // upper half reads as zero
         end else if (wdec == {1'b1, SLOT_STAT} && s_axi_wstrb[0] &&
                      s_axi_wdata[STAT_CERR_BIT]) begin
            nxt_s.cfg_err = 1'b0;
         end
      end
      if (rd_go) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = rdec[3] ? RESP_OKAY : RESP_SLVERR;
         nxt_s.rdata = 32'h0000_0000;
         if (rdec == {1'b1, SLOT_CTRL}) begin
            nxt_s.rdata = ctrl_word(s_ff.cfg);
         end else if (rdec[3] && rdec[2:0] >= SLOT_FLEN1 && rdec[2:0] < SLOT_STAT) begin
            nxt_s.rdata = {16'h0000, s_ff.flen[rdec[2:0] - SLOT_FLEN1]};
         end else if (rdec == {1'b1, SLOT_STAT}) begin
            nxt_s.rdata[STAT_BUSY_BIT] = (s_ff.st == ST_RUN);
            nxt_s.rdata[STAT_CERR_BIT] = s_ff.cfg_err;
            nxt_s.rdata[STAT_CFGOK_BIT] = good;
            nxt_s.rdata[STAT_PKTS_LSB +: 8] = s_ff.pkts;
            nxt_s.rdata[STAT_LVL_LSB +: LW] = f_level;
         end else if (rdec == {1'b1, SLOT_DATA}) begin
            nxt_s.rdata[DATA_VALID_BIT] = f_valid;
            nxt_s.rdata[7:0] = f_valid ? f_data : 8'h00;
         end
      end
      // field walker
      case (s_ff.st)
         ST_IDLE: begin
            // a first byte with a good layout waits here; strays are dropped
            rx_ready = rx_valid && !(rx_byte.first && good);
            if (rx_valid && rx_byte.first) begin
               if (good) begin
                  nxt_s.st = ST_RUN;
                  nxt_s.fld = 3'h1;
                  nxt_s.cnt = 16'h0000;
                  nxt_s.vlen = 16'h0000;
                  nxt_s.len_seen = 1'b0;
               end else begin
                  nxt_s.cfg_err = 1'b1;
               end
            end
         end
         ST_RUN: begin
            if (fdone) begin
               if (s_ff.fld == 3'h5) begin
                  nxt_s.st = ST_IDLE;
                  nxt_s.pkts = s_ff.pkts + 8'h01;
               end else begin
                  nxt_s.fld = s_ff.fld + 3'h1;
                  nxt_s.cnt = 16'h0000;
               end
            end else begin
               rx_ready = !keep || f_in_ready;
               take = rx_valid && rx_ready;
               push = take && keep;
               if (take) begin
                  nxt_s.cnt = s_ff.cnt + 16'h0001;
                  if (is_len) begin
                     if (!s_ff.cfg.two) begin
                        nxt_s.vlen = {8'h00, rx_byte.data};
                        nxt_s.len_seen = 1'b1;
                     end else if (s_ff.cnt == off16) begin
                        nxt_s.lenlo = rx_byte.data;
                     end else begin
                        nxt_s.vlen = s_ff.cfg.msbf ? {s_ff.lenlo, rx_byte.data}
                                                   : {rx_byte.data, s_ff.lenlo};
                        nxt_s.len_seen = 1'b1;
                     end
                  end
               end
            end
         end
         default: begin
            nxt_s.st = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
         s_ff.cfg.len_fld <= RST_LEN_FLD;
         s_ff.cfg.var_fld <= RST_VAR_FLD;
         s_ff.flen <= {NUM_FIELDS{RST_FLEN}};
      end else begin
         s_ff <= nxt_s;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_len_before_var: assert property (
      (s_ff.st == ST_RUN && s_ff.fld == s_ff.cfg.var_fld && !fdone) |-> s_ff.len_seen)
      else $error("variable field entered before its length was seen");

   chk_start_layout: assert property (
      (s_ff.st == ST_RUN && $past(s_ff.st) == ST_IDLE) |->
      (s_ff.cfg.len_fld inside {[3'h1:3'h4]}) && (s_ff.cfg.var_fld > s_ff.cfg.len_fld))
      else $error("packet started with length field out of range");

   chk_var_range: assert property (
      (s_ff.st == ST_RUN && $past(s_ff.st) == ST_IDLE) |->
      s_ff.cfg.var_fld inside {[3'h2:3'h5]})
      else $error("packet started with variable field out of range");

   chk_len_one_byte: assert property (
      (take && is_len && !s_ff.cfg.two) |=>
      (s_ff.vlen == {8'h00, $past(rx_byte.data)}) && s_ff.len_seen)
      else $error("one-byte length not decoded");

   chk_len_msb_first: assert property (
      (take && is_len && s_ff.cfg.two && s_ff.cfg.msbf && s_ff.cnt != off16) |=>
      s_ff.vlen == {$past(s_ff.lenlo), $past(rx_byte.data)})
      else $error("two-byte big-endian length wrong");

   chk_len_strip: assert property (
      take |-> (push == !(s_ff.cfg.strip && is_len)))
      else $error("length byte queueing does not follow strip option");

   chk_var_count: assert property (
      (fdone && s_ff.fld == s_ff.cfg.var_fld) |-> s_ff.cnt == s_ff.vlen)
      else $error("variable field byte count differs from length");

   chk_field_step: assert property (
      (fdone && s_ff.fld != 3'h5) |-> !take ##1 ((s_ff.fld == $past(s_ff.fld) + 3'h1) &&
      (s_ff.cnt == 16'h0000)))
      else $error("field walk skipped or repeated a field");

   chk_write_answer: assert property (
      wr_go |=> s_ff.bvalid && !s_axi_awready)
      else $error("write not answered");
endmodule

// ---- tb/vlfrx_tx_model.sv ----
// transmitter model: holds a whole packet, then streams it byte by byte
`timescale 1ns/10ps
module vlfrx_tx_model (
   // clock
   input wire logic aclk,
   // byte stream towards the receiver
   output logic rx_valid,
   output vlfrx_pkg::vlfrx_rxb_s rx_byte,
   input wire logic rx_ready
);
   import vlfrx_pkg::*;
   logic [7:0] q[$];
   // idle line at time zero
   initial begin
      rx_valid = 1'b0;
      rx_byte = '0;
   end
   // sends the loaded packet; gap idle cycles per byte model a slow sender
   task automatic send(input int gap);
      logic [7:0] b;
      logic first;
      first = 1'b1;
      b = 8'h00;
      @(posedge aclk);
      while (q.size() > 0) begin
         b = q.pop_front();
         rx_valid <= 1'b1;
         rx_byte <= '{first: first, data: b};
         do @(negedge aclk); while (rx_ready !== 1'b1);
         @(posedge aclk);
         first = 1'b0;
         repeat (gap) begin
            rx_valid <= 1'b0;
            rx_byte <= '{first: 1'b0, data: ~b}; // released data does not linger
            @(posedge aclk);
         end
      end
      rx_valid <= 1'b0;
      rx_byte <= '{first: 1'b0, data: ~b};
   endtask
endmodule

// ---- tb/variable_length_field_rx_bench.sv ----
// bench for the variable-length field receiver: bus tasks, packet table, fifo fill and drain
`timescale 1ns/10ps
module variable_length_field_rx_bench;
   import vlfrx_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [REG_AW-1:0] awaddr = '0;
   logic [REG_AW-1:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] strb = 4'hf;
   logic [2:0] prot = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   vlfrx_rxb_s rx_byte;
   int err_count = 0;
   int tests_run = 0;
   logic [7:0] exp_q[$];
   logic [31:0] d;

   // 25 MHz clock
   always #20 aclk = ~aclk;

   vlfrx_top #(.DEPTH(FIFO_DEPTH)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready)
   );

   vlfrx_tx_model tx_u (.aclk(aclk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready));

   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // axi4-lite write, waits for the response
   task automatic wr(input logic [5:0] a, input logic [31:0] dw, input logic [1:0] er);
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dw;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge aclk); while (awready !== 1'b1);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask

   // axi4-lite read, returns the data
   task automatic rd(input logic [5:0] a, output logic [31:0] dr, input logic [1:0] er);
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      r = rresp;
      dr = rdata;
      @(posedge aclk);
      rready <= 1'b0;
      chk("rresp", {30'h0, r}, {30'h0, er});
   endtask

   // program a layout and load a packet into the transmitter, expectations alongside
   task automatic setup(input logic [2:0] lf, input logic [2:0] vf, input logic two,
                        input logic msbf, input logic strip, input logic [7:0] off,
                        input logic [4:0][15:0] fl, input logic [15:0] vlen);
      int n;
      logic [7:0] b;
      logic ln;
      wr(OFS_CTRL, (32'(lf) << CTRL_LFLD_LSB) | (32'(vf) << CTRL_VFLD_LSB)
         | (32'(two) << CTRL_TWO_BIT) | (32'(msbf) << CTRL_MSBF_BIT)
         | (32'(strip) << CTRL_STRIP_BIT) | (32'(off) << CTRL_LOFF_LSB), RESP_OKAY);
      for (int f = 0; f < 5; f++) begin
         wr(6'(OFS_FLEN_BASE + OFS_FLEN_STEP * f), {16'h0, fl[f]}, RESP_OKAY);
      end
      for (int f = 1; f <= 5; f++) begin
         n = (f == vf) ? int'(vlen) : int'(fl[f-1]);
         for (int i = 0; i < n; i++) begin
            b = 8'(f * 41 + i);
            ln = 1'b0;
            if (f == lf && i == off) begin
               b = (two && msbf) ? vlen[15:8] : vlen[7:0];
               ln = 1'b1;
            end
            if (f == lf && two && i == off + 1) begin
               b = msbf ? vlen[7:0] : vlen[15:8];
               ln = 1'b1;
            end
            tx_u.q.push_back(b);
            if (!(strip && ln)) exp_q.push_back(b);
         end
      end
   endtask

   // poll status until the receiver is idle again
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         rd(OFS_STAT, d, RESP_OKAY);
         n++;
      end while (d[STAT_BUSY_BIT] !== 1'b0 && n < 300);
      chk("idle", {31'h0, d[STAT_BUSY_BIT]}, 32'h0);
   endtask

   // read every expected byte out of the queue, then check it is empty
   task automatic drain();
      while (exp_q.size() > 0) begin
         rd(OFS_DATA, d, RESP_OKAY);
         chk("data", {23'h0, d[8:0]}, {23'h0, 1'b1, exp_q.pop_front()});
      end
      rd(OFS_DATA, d, RESP_OKAY);
      chk("data empty", {31'h0, d[DATA_VALID_BIT]}, 32'h0);
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CTRL, d, RESP_OKAY);
      chk("ctrl reset", d, 32'h21);
      rd(OFS_FLEN_BASE, d, RESP_OKAY);
      chk("flen1 reset", d, 32'h1);
      rd(OFS_STAT, d, RESP_OKAY);
      chk("stat reset", d & 32'h003f0007, 32'h4);
      rd(6'h20, d, RESP_SLVERR);
      chk("unmapped", d, 32'h0);
      wr(6'h3c, 32'h1, RESP_SLVERR);
      // byte-lane strobes: only the low control byte may change
      strb <= 4'h1;
      wr(OFS_CTRL, 32'hffff_ff32, RESP_OKAY);
      strb <= 4'hf;
      rd(OFS_CTRL, d, RESP_OKAY);
      chk("ctrl strobe", d, 32'h32);
      // length and variable fields at various places, both orders, keep and strip
      setup(3'h1, 3'h2, 1'b0, 1'b0, 1'b0, 8'h0, {16'h0, 16'h0, 16'h0, 16'h0, 16'h1}, 16'h3);
      tx_u.send(0);
      wait_idle();
      drain();
      setup(3'h2, 3'h4, 1'b1, 1'b0, 1'b1, 8'h1, {16'h2, 16'h0, 16'h1, 16'h3, 16'h2}, 16'h5);
      tx_u.send(2);
      wait_idle();
      drain();
      setup(3'h4, 3'h5, 1'b1, 1'b1, 1'b0, 8'h0, {16'h0, 16'h2, 16'h1, 16'h1, 16'h1}, 16'h4);
      tx_u.send(1);
      wait_idle();
      drain();
      setup(3'h1, 3'h5, 1'b0, 1'b0, 1'b1, 8'h0, {16'h0, 16'h1, 16'h2, 16'h0, 16'h1}, 16'h0);
      tx_u.send(0);
      wait_idle();
      drain();
      rd(OFS_STAT, d, RESP_OKAY);
      chk("packets", {24'h0, d[STAT_PKTS_LSB +: 8]}, 32'h4);
      // layouts with the variable field not after the length field
      for (int k = 0; k < 2; k++) begin
         setup(k ? 3'h1 : 3'h3, k ? 3'h1 : 3'h3, 1'b0, 1'b0, 1'b0, 8'h0, {5{16'h1}}, 16'h0);
         tx_u.q.delete();
         exp_q.delete();
         tx_u.q.push_back(8'h5a);
         tx_u.send(0);
         rd(OFS_STAT, d, RESP_OKAY);
         chk("layout bad", {29'h0, d[2:0]}, 32'h2);
         wr(OFS_STAT, 32'h2, RESP_OKAY);
         rd(OFS_STAT, d, RESP_OKAY);
         chk("error cleared", {31'h0, d[STAT_CERR_BIT]}, 32'h0);
      end
      // long packet fills the fifo and stalls the sender, then drains
      setup(3'h1, 3'h2, 1'b0, 1'b0, 1'b0, 8'h0, {16'h0, 16'h0, 16'h0, 16'h0, 16'h1}, 16'd40);
      fork
         tx_u.send(0);
      join_none
      for (int n = 0; n < 200; n++) begin
         rd(OFS_STAT, d, RESP_OKAY);
         if (d[STAT_LVL_LSB +: 6] === 6'd32) break;
      end
      chk("fifo full", {26'h0, d[STAT_LVL_LSB +: 6]}, 32'd32);
      chk("busy", {31'h0, d[STAT_BUSY_BIT]}, 32'h1);
      @(negedge aclk);
      chk("stalled", {31'h0, rx_ready}, 32'h0);
      drain();
      wait_idle();
      chk("packets", {24'h0, d[STAT_PKTS_LSB +: 8]}, 32'h5);
      tally_and_finish();
   end
endmodule
